// ### src/abn_encoder_interface.sv
// Behaviour
// - Signed 32-bit encoder position, readable and writable by software at any time.
// - Step constant is signed fixed point: 16 integer bits, 16 fraction bits.
// - Decimal-select bit: fraction counts in 65536ths when clear, 10000ths when set.
// - Flags: bit 0 index event, bit 1 deviation warning; writing one clears.
// - Deviation warning cannot be cleared while the deviation persists.
// - Both flags are ORed onto the interrupt output while set and enabled in the interrupt mask.
// - Qualified index event copies position into read-only latched-position register.
// - Deviation beyond 20-bit limit sets warning; limit zero disables the check.
// - Mode bit 9 also latches the ramp actual position on index latch.
// - Mode bit 8 clears the position to zero after latching it.
// - Mode bits 7:6 pick level, active edge, inactive edge or both edges.
// - Mode bit 5 latches only on the first index event after the write.
// - Mode bit 4 latches on every index event.
// - Mode bit 3 clear: index counts only when A and B levels match.
// - Mode bit 2 sets the index active level: 0 low, 1 high.
// - Mode bits 0 and 1 give required A and B levels.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module abn_encoder_interface
    import abn_encoder_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    input  wire logic              enc_a_i,
    input  wire logic              enc_b_i,
    input  wire logic              enc_n_i,
    input  wire logic [31:0]       ramp_actual_position_i,
    output logic                   irq_o
);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[8*i +: 8] = new_v[8*i +: 8];
        end
        return res;
    endfunction

    // Bus state
    wr_state_e         wr_state_ff;
    rd_state_e         rd_state_ff;
    logic              aw_held_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic              w_held_ff;
    logic [31:0]       w_data_ff;
    logic [3:0]        w_strb_ff;
    logic [1:0]        bresp_ff;
    logic [31:0]       rdata_ff;
    logic [1:0]        rresp_ff;

    // Block state
    enc_mode_s         mode_ff;
    logic [31:0]       const_ff;
    logic [19:0]       limit_ff;
    logic [1:0]        mask_ff;
    logic [1:0]        flags_ff;
    logic [31:0]       pos_ff;
    logic [15:0]       frac_ff;
    logic [31:0]       latch_ff;
    logic [31:0]       ramp_latch_ff;
    logic              once_armed_ff;
    logic [2:0]        in_meta_ff;
    logic [2:0]        in_sync_ff;
    logic [2:0]        in_prev_ff;
    logic              qual_prev_ff;

    // Write decode
    logic              do_write;
    logic [5:0]        wr_idx;
    logic [31:0]       wr_word;
    logic              wr_mode;
    logic              wr_pos;
    logic              wr_const;
    logic              wr_flags;
    logic              wr_limit;
    logic              wr_mask;
    logic              wr_known;
    assign s_axi_awready_o = (wr_state_ff == WR_IDLE) && !aw_held_ff;
    assign s_axi_wready_o  = (wr_state_ff == WR_IDLE) && !w_held_ff;
    assign s_axi_bvalid_o  = (wr_state_ff == WR_RESP);
    assign s_axi_bresp_o   = bresp_ff;
    assign s_axi_arready_o = (rd_state_ff == RD_IDLE);
    assign s_axi_rvalid_o  = (rd_state_ff == RD_DATA);
    assign s_axi_rdata_o   = rdata_ff;
    assign s_axi_rresp_o   = rresp_ff;
    assign do_write = (wr_state_ff == WR_IDLE) && aw_held_ff && w_held_ff;
    assign wr_idx   = aw_addr_ff[7:2];
    assign wr_mode  = do_write && (wr_idx == IDX_MODE);
    assign wr_pos   = do_write && (wr_idx == IDX_POSITION);
    assign wr_const = do_write && (wr_idx == IDX_STEP_CONST);
    assign wr_flags = do_write && (wr_idx == IDX_FLAGS);
    assign wr_limit = do_write && (wr_idx == IDX_DEV_LIMIT);
    assign wr_mask  = do_write && (wr_idx == IDX_IRQ_MASK);
    assign wr_known = (wr_idx >= IDX_MODE) && (wr_idx <= IDX_RAMP_LATCH);

    // Address and data are taken in either order and held until both are in
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_held_ff  <= 1'b0;
            w_data_ff  <= WORD_RST;
            w_strb_ff  <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr_i;
            end else if (do_write) begin
                aw_held_ff <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata_i;
                w_strb_ff <= s_axi_wstrb_i;
            end else if (do_write) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wr_state_ff <= WR_IDLE;
            bresp_ff    <= RESP_OKAY;
        end else begin
            case (wr_state_ff)
                WR_IDLE: begin
                    if (do_write) begin
                        wr_state_ff <= WR_RESP;
                        bresp_ff    <= wr_known ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready_i) begin
                        wr_state_ff <= WR_IDLE;
                    end
                end
                default: wr_state_ff <= WR_IDLE;
            endcase
        end
    end

    // Read data is sampled at the address handshake
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rd_state_ff <= RD_IDLE;
            rdata_ff    <= WORD_RST;
            rresp_ff    <= RESP_OKAY;
        end else begin
            case (rd_state_ff)
                RD_IDLE: begin
                    if (s_axi_arvalid_i) begin
                        rd_state_ff <= RD_DATA;
                        rresp_ff    <= RESP_OKAY;
                        case (s_axi_araddr_i[7:2])
                            IDX_MODE:       rdata_ff <= {21'h0, mode_ff};
                            IDX_POSITION:   rdata_ff <= pos_ff;
                            IDX_FLAGS:      rdata_ff <= {30'h0, flags_ff};
                            IDX_LATCH:      rdata_ff <= latch_ff;
                            IDX_IRQ_MASK:   rdata_ff <= {30'h0, mask_ff};
                            IDX_RAMP_LATCH: rdata_ff <= ramp_latch_ff;
                            IDX_STEP_CONST,
                            IDX_DEV_LIMIT:  rdata_ff <= WORD_RST;
                            default: begin
                                rdata_ff <= WORD_RST;
                                rresp_ff <= RESP_SLVERR;
                            end
                        endcase
                    end
                end
                RD_DATA: begin
                    if (s_axi_rready_i) begin
                        rd_state_ff <= RD_IDLE;
                    end
                end
                default: rd_state_ff <= RD_IDLE;
            endcase
        end
    end

    // Software configuration registers
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            mode_ff  <= enc_mode_s'(MODE_RST);
            const_ff <= CONST_RST;
            limit_ff <= LIMIT_RST;
            mask_ff  <= MASK_RST;
        end else begin
            if (wr_mode) mode_ff <= enc_mode_s'(wr_word[MODE_W-1:0]);
            if (wr_const) const_ff <= wr_word;
            if (wr_limit) limit_ff <= wr_word[LIMIT_W-1:0];
            if (wr_mask) mask_ff <= wr_word[FLAG_W-1:0];
        end
    end
    always_comb begin
        case (wr_idx)
            IDX_MODE:       wr_word = merge_bytes({21'h0, mode_ff}, w_data_ff, w_strb_ff);
            IDX_POSITION:   wr_word = merge_bytes(pos_ff, w_data_ff, w_strb_ff);
            IDX_STEP_CONST: wr_word = merge_bytes(const_ff, w_data_ff, w_strb_ff);
            IDX_DEV_LIMIT:  wr_word = merge_bytes({12'h0, limit_ff}, w_data_ff, w_strb_ff);
            default:        wr_word = merge_bytes(WORD_RST, w_data_ff, w_strb_ff);
        endcase
    end

    // Input synchronisers: stage one feeds only stage two
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            in_meta_ff <= 3'h0;
            in_sync_ff <= 3'h0;
            in_prev_ff <= 3'h0;
        end else begin
            in_meta_ff <= {enc_n_i, enc_b_i, enc_a_i};
            in_sync_ff <= in_meta_ff;
            in_prev_ff <= in_sync_ff;
        end
    end

    // Quadrature decode and fixed-point accumulation
    logic        chg_a;
    logic        chg_b;
    logic        quad_step;
    logic        quad_up;
    logic [17:0] frac_mod;
    logic [17:0] frac_sum;
    logic [17:0] frac_dif;
    logic        carry;
    logic        borrow;
    logic [15:0] nxt_frac;
    logic [31:0] step_int;
    logic [31:0] nxt_pos_step;
    assign chg_a     = in_sync_ff[0] ^ in_prev_ff[0];
    assign chg_b     = in_sync_ff[1] ^ in_prev_ff[1];
    assign quad_step = chg_a ^ chg_b;
    assign quad_up   = ~(in_prev_ff[0] ^ in_sync_ff[1]);
    assign frac_mod  = mode_ff.sel_decimal ? FRAC_DEC_MOD : FRAC_BIN_MOD;
    assign frac_sum  = {2'h0, frac_ff} + {2'h0, const_ff[15:0]};
    assign frac_dif  = {2'h0, frac_ff} - {2'h0, const_ff[15:0]};
    assign carry     = (frac_sum >= frac_mod);
    assign borrow    = frac_dif[17];
    assign step_int  = {{16{const_ff[31]}}, const_ff[31:16]};
    always_comb begin
        if (quad_up) begin
            nxt_frac     = carry ? 16'(frac_sum - frac_mod) : frac_sum[15:0];
            nxt_pos_step = pos_ff + step_int + {31'h0, carry};
        end else begin
            nxt_frac     = borrow ? 16'(frac_dif + frac_mod) : frac_dif[15:0];
            nxt_pos_step = pos_ff - step_int - {31'h0, borrow};
        end
    end

    // Index qualification and event detection
    logic qual_now;
    logic index_evt;
    logic latch_go;
    assign qual_now = (in_sync_ff[2] == mode_ff.pol_index) &&
                      (mode_ff.skip_quadrature_qualify ||
                       ((in_sync_ff[0] == mode_ff.pol_a) &&
                        (in_sync_ff[1] == mode_ff.pol_b)));

    always_comb begin
        case ({mode_ff.edge_inactive, mode_ff.edge_active})
            2'b00:   index_evt = qual_now;
            2'b01:   index_evt = qual_now && !qual_prev_ff;
            2'b10:   index_evt = !qual_now && qual_prev_ff;
            default: index_evt = qual_now ^ qual_prev_ff;
        endcase
    end

    assign latch_go = index_evt && (mode_ff.latch_always || once_armed_ff);
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            qual_prev_ff  <= 1'b0;
            once_armed_ff <= 1'b0;
        end else begin
            qual_prev_ff <= qual_now;
            if (wr_mode) begin
                once_armed_ff <= wr_word[5];
            end else if (latch_go) begin
                once_armed_ff <= 1'b0;
            end
        end
    end

    // Position: software write beats index clear, which beats counting
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pos_ff  <= WORD_RST;
            frac_ff <= 16'h0000;
        end else if (wr_pos) begin
            pos_ff  <= wr_word;
            frac_ff <= 16'h0000;
        end else if (latch_go && mode_ff.clear_on_latch) begin
            pos_ff  <= WORD_RST;
            frac_ff <= 16'h0000;
        end else if (quad_step) begin
            pos_ff  <= nxt_pos_step;
            frac_ff <= nxt_frac;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            latch_ff      <= WORD_RST;
            ramp_latch_ff <= WORD_RST;
        end else if (latch_go) begin
            latch_ff <= pos_ff;
            if (mode_ff.latch_ramp) begin
                ramp_latch_ff <= ramp_actual_position_i;
            end
        end
    end

    // Deviation check and sticky flags; a set beats a clear
    logic [32:0] dev_diff;
    logic [32:0] dev_abs;
    logic        dev_cond;
    logic [1:0]  flag_set;
    logic [1:0]  flag_clr;
    assign dev_diff = {pos_ff[31], pos_ff} - {ramp_actual_position_i[31], ramp_actual_position_i};
    assign dev_abs  = dev_diff[32] ? 33'(-dev_diff) : dev_diff;
    assign dev_cond = (limit_ff != LIMIT_RST) && (dev_abs > {13'h0, limit_ff});
    assign flag_set = {dev_cond, index_evt};
    assign flag_clr = (wr_flags && w_strb_ff[0]) ? w_data_ff[1:0] : 2'h0;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            flags_ff <= 2'h0;
        end else begin
            flags_ff <= flag_set | (flags_ff & ~flag_clr);
        end
    end

    assign irq_o = |(flags_ff & mask_ff);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    pos_sw_write_a: assert property (
        wr_pos && (w_strb_ff == 4'hF) |=> pos_ff == $past(w_data_ff))
        else $error("position did not take software write");
    int_step_a: assert property (
        quad_step && quad_up && !wr_pos && !latch_go && (const_ff[15:0] == 16'h0000)
        |=> pos_ff == $past(pos_ff) + $past(step_int))
        else $error("integer step not added");
    dec_frac_range_a: assert property (
        mode_ff.sel_decimal && quad_step && !wr_pos && !latch_go &&
        ({2'h0, frac_ff} < FRAC_DEC_MOD) && ({2'h0, const_ff[15:0]} < FRAC_DEC_MOD)
        |=> {2'h0, frac_ff} < FRAC_DEC_MOD)
        else $error("decimal fraction out of range");
    index_flag_clear_a: assert property (
        wr_flags && w_strb_ff[0] && w_data_ff[0] && !index_evt |=> !flags_ff[0])
        else $error("index flag not cleared");
    dev_flag_hold_a: assert property (
        dev_cond |=> flags_ff[1] && irq_o == (mask_ff[1] || (flags_ff[0] && mask_ff[0])))
        else $error("deviation flag lost while condition persists");
    irq_level_a: assert property (
        (flags_ff != 2'h0) && (mask_ff == MASK_RST) |-> irq_o) else $error("irq low, flag set");
    latch_copy_a: assert property (
        latch_go |=> latch_ff == $past(pos_ff)) else $error("latched position wrong");
    dev_off_a: assert property (
        (limit_ff == LIMIT_RST) && !wr_flags |=> flags_ff[1] == $past(flags_ff[1]))
        else $error("deviation flag changed while check disabled");
    ramp_latch_a: assert property (
        latch_go && mode_ff.latch_ramp |=> ramp_latch_ff == $past(ramp_actual_position_i))
        else $error("ramp position not latched");
    clear_on_latch_a: assert property (
        latch_go && mode_ff.clear_on_latch && !wr_pos |=> pos_ff == WORD_RST)
        else $error("position not cleared on latch");
    rise_only_a: assert property (
        ({mode_ff.edge_inactive, mode_ff.edge_active} == 2'b01) && $stable(qual_now)
        |-> !index_evt)
        else $error("event without active edge");
    once_disarm_a: assert property (
        latch_go && !wr_mode |=> !once_armed_ff) else $error("one-shot latch stayed armed");

endmodule // abn_encoder_interface

// ### src/abn_encoder_pkg.sv
package abn_encoder_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [5:0] IDX_MODE       = 6'h38;
    localparam logic [5:0] IDX_POSITION   = 6'h39;
    localparam logic [5:0] IDX_STEP_CONST = 6'h3A;
    localparam logic [5:0] IDX_FLAGS      = 6'h3B;
    localparam logic [5:0] IDX_LATCH      = 6'h3C;
    localparam logic [5:0] IDX_DEV_LIMIT  = 6'h3D;
    localparam logic [5:0] IDX_IRQ_MASK   = 6'h3E;
    localparam logic [5:0] IDX_RAMP_LATCH = 6'h3F;

    localparam int ADDR_W  = 8;
    localparam int MODE_W  = 11;
    localparam int LIMIT_W = 20;
    localparam int FLAG_W  = 2;

    // Flag bit positions
    localparam int FLAG_INDEX = 0;
    localparam int FLAG_DEV   = 1;

    // Reset values
    localparam logic [10:0] MODE_RST  = 11'h000;
    localparam logic [31:0] CONST_RST = 32'h0001_0000;
    localparam logic [19:0] LIMIT_RST = 20'h0_0000;
    localparam logic [1:0]  MASK_RST  = 2'h3;
    localparam logic [31:0] WORD_RST  = 32'h0000_0000;

    // Fraction moduli for binary and decimal prescaling
    localparam logic [17:0] FRAC_BIN_MOD = 18'h1_0000;
    localparam logic [17:0] FRAC_DEC_MOD = 18'h0_2710;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Mode register layout, bit 10 down to bit 0
    typedef struct packed {
        logic sel_decimal;
        logic latch_ramp;
        logic clear_on_latch;
        logic edge_inactive;
        logic edge_active;
        logic latch_once;
        logic latch_always;
        logic skip_quadrature_qualify;
        logic pol_index;
        logic pol_b;
        logic pol_a;
    } enc_mode_s;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_e;

endpackage

// ### bench/quad_encoder_model.sv
`timescale 1ns/1ns
module quad_encoder_model (
    input  wire logic clock_i,
    output logic      enc_a_o,
    output logic      enc_b_o,
    output logic      enc_n_o
);
    logic [1:0] phase;

    initial begin
        phase = 2'h0;
        enc_a_o = 1'b0;
        enc_b_o = 1'b0;
        enc_n_o = 1'b0;
    end

    // Gray order 00,10,11,01 counting up; each level holds at least six clocks
    task automatic step(input logic up);
        @(posedge clock_i);
        phase = up ? phase + 2'h1 : phase - 2'h1;
        enc_a_o <= phase[1] ^ phase[0];
        enc_b_o <= phase[1];
        repeat (5) @(posedge clock_i);
    endtask

    task automatic pulse(input logic act);
        @(posedge clock_i);
        enc_n_o <= act;
        repeat (5) @(posedge clock_i);
        enc_n_o <= ~act;
        repeat (5) @(posedge clock_i);
    endtask
endmodule // quad_encoder_model

// ### bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import abn_encoder_pkg::*;
    logic        clock_i = 1'b0, rst_n_i = 1'b0;
    logic [7:0]  aw_addr = 8'h00, ar_addr = 8'h00;
    logic [31:0] w_data = 32'h0000_0000, ramp_pos = 32'h0000_0000, r_data;
    logic        aw_vld = 1'b0, w_vld = 1'b0, b_rdy = 1'b0, ar_vld = 1'b0, r_rdy = 1'b0;
    logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq, ea, eb, en;
    logic [1:0]  b_resp, r_resp, rs;
    logic [3:0]  w_strb = 4'hF;
    logic [31:0] rd;
    int          err_total = 0, n_checks = 0;

    always #25 clock_i = ~clock_i;

    abn_encoder_interface dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_vld), .s_axi_awready_o(aw_rdy),
        .s_axi_wdata_i(w_data), .s_axi_wstrb_i(w_strb), .s_axi_wvalid_i(w_vld),
        .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_vld),
        .s_axi_bready_i(b_rdy), .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_vld),
        .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
        .s_axi_rvalid_o(r_vld), .s_axi_rready_i(r_rdy), .enc_a_i(ea), .enc_b_i(eb),
        .enc_n_i(en), .ramp_actual_position_i(ramp_pos), .irq_o(irq));
    quad_encoder_model enc_u (.clock_i(clock_i), .enc_a_o(ea), .enc_b_o(eb), .enc_n_o(en));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        int t;
        @(posedge clock_i);
        aw_addr <= {i, 2'b00};
        w_data <= d;
        aw_vld <= 1'b1;
        w_vld <= 1'b1;
        b_rdy <= 1'b1;
        t = 0;
        do begin
            @(posedge clock_i);
            t++;
            if (aw_vld && aw_rdy) aw_vld <= 1'b0;
            if (w_vld && w_rdy) w_vld <= 1'b0;
        end while (b_vld !== 1'b1 && t < 100);
        rs = b_resp;
        b_rdy <= 1'b0;
        if (t >= 100) err_total++;
    endtask

    task automatic rdr(input logic [5:0] i);
        int t;
        @(posedge clock_i);
        ar_addr <= {i, 2'b00};
        ar_vld <= 1'b1;
        r_rdy <= 1'b1;
        t = 0;
        do begin
            @(posedge clock_i);
            t++;
            if (ar_vld && ar_rdy) ar_vld <= 1'b0;
        end while (r_vld !== 1'b1 && t < 100);
        rd = r_data;
        rs = r_resp;
        r_rdy <= 1'b0;
        if (t >= 100) err_total++;
    endtask

    task automatic t_reset;
        rdr(IDX_MODE);       chk("mode", 32'h0000_0000, rd);
        rdr(IDX_STEP_CONST); chk("const", 32'h0000_0000, rd);
        // Level mode, active-low index idling low, A and B at 00: event flag sets at once
        rdr(IDX_FLAGS);      chk("flags", 32'h0000_0001, rd);
        rdr(IDX_IRQ_MASK);   chk("mask", 32'h0000_0003, rd);
        rdr(6'h00);          chk("unmapped", 32'h0000_0002, {30'h0, rs});
        $display("test reset done");
    endtask

    task automatic t_count;
        repeat (6) enc_u.step(1'b1);
        repeat (2) enc_u.step(1'b0);
        rdr(IDX_POSITION); chk("count", 32'h0000_0004, rd);
        wr(IDX_STEP_CONST, 32'h0000_1388);
        wr(IDX_MODE, 32'h0000_0400);
        repeat (2) enc_u.step(1'b1);
        rdr(IDX_POSITION); chk("dec_up", 32'h0000_0005, rd);
        wr(IDX_STEP_CONST, 32'h0000_8000);
        wr(IDX_MODE, 32'h0000_0000);
        repeat (2) enc_u.step(1'b0);
        rdr(IDX_POSITION); chk("bin_down", 32'h0000_0004, rd);
        $display("test count done");
    endtask

    task automatic t_qualify;
        wr(IDX_MODE, 32'h0000_0057);
        wr(IDX_FLAGS, 32'h0000_0001);
        enc_u.pulse(1'b1);
        rdr(IDX_FLAGS); chk("no_match", 32'h0000_0000, rd);
        wr(IDX_MODE, 32'h0000_0054);
        enc_u.pulse(1'b1);
        rdr(IDX_FLAGS); chk("match", 32'h0000_0001, rd);
        rdr(IDX_LATCH); chk("latch", 32'h0000_0004, rd);
        wr(IDX_FLAGS, 32'h0000_0001);
        $display("test qualify done");
    endtask

    task automatic t_index;
        ramp_pos <= 32'h0000_1234;
        wr(IDX_MODE, 32'h0000_035C);
        wr(IDX_POSITION, 32'h0000_0037);
        rdr(IDX_POSITION); chk("pos_wr", 32'h0000_0037, rd);
        enc_u.pulse(1'b1);
        rdr(IDX_LATCH);      chk("latch", 32'h0000_0037, rd);
        rdr(IDX_RAMP_LATCH); chk("ramp", 32'h0000_1234, rd);
        rdr(IDX_POSITION);   chk("cleared", 32'h0000_0000, rd);
        chk("irq_on", 32'h0000_0001, {31'h0, irq});
        wr(IDX_FLAGS, 32'h0000_0001);
        rdr(IDX_FLAGS); chk("w1c", 32'h0000_0000, rd);
        chk("irq_off", 32'h0000_0000, {31'h0, irq});
        ramp_pos <= 32'h0000_0000;
        $display("test index done");
    endtask

    task automatic t_deviation;
        // Index active high and idle low, so no index events disturb the flags
        wr(IDX_MODE, 32'h0000_0004);
        wr(IDX_DEV_LIMIT, 32'h0000_0003);
        wr(IDX_POSITION, 32'h0000_0003);
        rdr(IDX_FLAGS); chk("at_limit", 32'h0000_0000, rd);
        wr(IDX_POSITION, 32'h0000_0004);
        rdr(IDX_FLAGS); chk("over", 32'h0000_0002, rd);
        wr(IDX_FLAGS, 32'h0000_0002);
        rdr(IDX_FLAGS); chk("sticky", 32'h0000_0002, rd);
        chk("irq_dev", 32'h0000_0001, {31'h0, irq});
        wr(IDX_DEV_LIMIT, 32'h0000_0000);
        wr(IDX_FLAGS, 32'h0000_0002);
        rdr(IDX_FLAGS); chk("off", 32'h0000_0000, rd);
        $display("test deviation done");
    endtask

    task automatic t_once;
        wr(IDX_MODE, 32'h0000_00AC);
        wr(IDX_IRQ_MASK, 32'h0000_0000);
        enc_u.pulse(1'b1);
        rdr(IDX_LATCH); chk("once_first", 32'h0000_0004, rd);
        chk("irq_masked", 32'h0000_0000, {31'h0, irq});
        rdr(IDX_FLAGS); chk("evt_flag", 32'h0000_0001, rd);
        wr(IDX_IRQ_MASK, 32'h0000_0003);
        chk("irq_unmasked", 32'h0000_0001, {31'h0, irq});
        w_strb <= 4'h1;
        wr(IDX_POSITION, 32'hFFFF_FF55);
        w_strb <= 4'hF;
        rdr(IDX_POSITION); chk("strobe", 32'h0000_0055, rd);
        enc_u.pulse(1'b1);
        rdr(IDX_LATCH); chk("once_spent", 32'h0000_0004, rd);
        wr(IDX_MODE, 32'h0000_00EC);
        enc_u.pulse(1'b1);
        rdr(IDX_LATCH); chk("once_rearm", 32'h0000_0055, rd);
        wr(IDX_FLAGS, 32'h0000_0001);
        $display("test once done");
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_reset;
        t_count;
        t_qualify;
        t_index;
        t_deviation;
        t_once;
        wrap_up;
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        wrap_up;
    end
endmodule // tb_top
